// >>> common/step_vel_regs.svh
`ifndef STEP_VEL_REGS_SVH
`define STEP_VEL_REGS_SVH
// Positions per revolution in each sequencing mode
`define USTEP_PER_REV    16'd12800
`define FSTEP_PER_REV    16'd200
// Microsteps advanced by one full step (12800 / 200)
`define USTEP_PER_FSTEP  32'sd64
// Largest programmable analog maximum velocity, rev/s
`define VEL_MAX_RPS      8'd50
// Analog code at 0 V (mid scale of 256 codes over 20 V)
`define ANALOG_ZERO_CODE 8'h80
// Reset values
`define POS_RESET        32'sd0
`define VAR_RESET        32'sd0
// Wait count that ends the unpowered wait before autostart (power is off six cycles)
`define SOFT_RST_CYCLES  4'd4
`endif

// >>> common/step_vel_pkg.sv
package step_vel_pkg;
  // Sequencing mode of the windings
  typedef enum logic [0:0] {
    MODE_MICRO = 1'b0,
    MODE_FULL  = 1'b1
  } step_mode_t;

  // Soft reset sequencer states
  typedef enum logic [1:0] {
    RST_IDLE  = 2'b00,
    RST_CLEAR = 2'b01,
    RST_WAIT  = 2'b10,
    RST_START = 2'b11
  } rst_state_t;

  // Velocity configuration, rev/s in 8.8 fixed point
  typedef struct packed {
    logic        fstep_en;
    logic [15:0] fstep_vel;
    logic [15:0] analog_max;
    logic [15:0] deadband;
  } vel_cfg_t;

  // Motion command toward the windings
  typedef struct packed {
    logic               dir_cw;
    logic signed [16:0] vel;
  } vel_cmd_t;
endpackage : step_vel_pkg

// >>> hw/user_var_mem.sv
`timescale 1ns/1ps
`include "step_vel_regs.svh"
// User variable store with registered read and a bulk clear
module user_var_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic               core_clk_i,
  input  wire logic               clr_i,
  input  wire logic               we_i,
  input  wire logic [AW-1:0]      waddr_i,
  input  wire logic signed [31:0] wdata_i,
  input  wire logic [AW-1:0]      raddr_i,
  output logic signed [31:0]      rdata_o
);
  logic signed [31:0] mem [DEPTH];

  // Every entry clears together on a soft reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge core_clk_i) begin
      if (clr_i) begin
        mem[i] <= `VAR_RESET;
      end else if (we_i && waddr_i == AW'(i)) begin
        mem[i] <= wdata_i;
      end
    end
  end

  // Registered read port
  always_ff @(posedge core_clk_i) begin
    if (clr_i) begin
      rdata_o <= `VAR_RESET;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : user_var_mem

// >>> hw/step_mode_velocity_control.sv
`timescale 1ns/1ps
`include "step_vel_regs.svh"
module step_mode_velocity_control #(
  parameter int VAR_DEPTH = 16,
  parameter int VAR_AW    = 4
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire step_vel_pkg::vel_cfg_t cfg_i,
  input  wire logic                   analog_follow_i,
  input  wire logic                   adc_valid_i,
  input  wire logic [7:0]             adc_code_i,
  input  wire logic signed [16:0]     seq_vel_i,
  input  wire logic                   step_pulse_i,
  input  wire logic                   soft_reset_i,
  input  wire logic                   var_we_i,
  input  wire logic [VAR_AW-1:0]      var_waddr_i,
  input  wire logic signed [31:0]     var_wdata_i,
  input  wire logic                   var_load_analog_i,
  input  wire logic [VAR_AW-1:0]      var_raddr_i,
  output logic signed [31:0]          var_rdata_o,
  output logic [7:0]                  analog_reg_o,
  output step_vel_pkg::vel_cmd_t      cmd_o,
  output step_vel_pkg::step_mode_t    mode_o,
  output logic signed [31:0]          position_o,
  output logic                        motor_power_o,
  output logic                        seq_halt_o,
  output logic                        autostart_o
);
  logic [7:0]                analog_reg;
  logic signed [16:0]        cmd_vel_reg;
  logic signed [16:0]        cmd_vel_next;
  step_vel_pkg::step_mode_t  mode_reg;
  step_vel_pkg::step_mode_t  mode_next;
  logic signed [31:0]        pos_reg;
  logic signed [31:0]        pos_next;
  step_vel_pkg::rst_state_t  rst_state_reg;
  step_vel_pkg::rst_state_t  rst_state_next;
  logic [3:0]                rst_cnt_reg;
  logic                      power_reg;
  logic                      halt_reg;
  logic                      auto_reg;
  logic                      dir_reg;

  // Analog code held on each conversion
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      analog_reg <= `ANALOG_ZERO_CODE;
    end else if (adc_valid_i) begin
      analog_reg <= adc_code_i;
    end
  end

  // Signed code about mid scale: -128..127
  wire logic signed [8:0]  code_s = $signed({1'b0, analog_reg})
                                    - $signed({1'b0, `ANALOG_ZERO_CODE});
  // Maximum clamped to 50 rev/s in 8.8 fixed point
  wire logic [15:0] max_lim = {`VEL_MAX_RPS, 8'h00};
  wire logic [15:0] amax = (cfg_i.analog_max > max_lim) ? max_lim
                           : cfg_i.analog_max;
  // Linear scaling, full scale at signed code -128 (code 0x00)
  wire logic signed [25:0] prod = code_s * $signed({1'b0, amax});
  wire logic signed [16:0] analog_vel = 17'(prod >>> 7);
  // Deadband taken as a magnitude, negative settings mirrored
  wire logic [15:0] db_mag = cfg_i.deadband[15] ? 16'(-cfg_i.deadband)
                             : cfg_i.deadband;
  wire logic [16:0] av_mag = analog_vel[16] ? 17'(-analog_vel)
                             : 17'(analog_vel);
  wire logic in_db = av_mag <= {1'b0, db_mag};
  wire logic signed [16:0] follow_vel = in_db ? 17'sd0 : analog_vel;

  // Commanded velocity source; zero while halted
  always_comb begin
    if (halt_reg) begin
      cmd_vel_next = 17'sd0;
    end else if (analog_follow_i) begin
      cmd_vel_next = follow_vel;
    end else begin
      cmd_vel_next = seq_vel_i;
    end
  end

  // Mode switching on velocity magnitude
  wire logic [16:0] cmd_mag = cmd_vel_reg[16] ? 17'(-cmd_vel_reg)
                              : 17'(cmd_vel_reg);
  wire logic at_full = cfg_i.fstep_en
                       && cmd_mag >= {1'b0, cfg_i.fstep_vel};
  // Entry waits until the next position lands on a full step, so a step
  // in the same cycle cannot leave full-step mode off the boundary
  wire logic on_fstep = pos_next[5:0] == 6'h00;
  always_comb begin
    mode_next = mode_reg;
    if (!at_full) begin
      mode_next = step_vel_pkg::MODE_MICRO;
    end else if (on_fstep) begin
      mode_next = step_vel_pkg::MODE_FULL;
    end
  end

  // Position advances by 1 or 64 per step, in step direction
  wire logic signed [31:0] stride = (mode_reg == step_vel_pkg::MODE_FULL)
                                    ? `USTEP_PER_FSTEP : 32'sd1;
  always_comb begin
    pos_next = pos_reg;
    if (rst_state_reg == step_vel_pkg::RST_CLEAR) begin
      pos_next = `POS_RESET;
    end else if (step_pulse_i && power_reg) begin
      pos_next = cmd_vel_reg[16] ? pos_reg - stride
                 : pos_reg + stride;
    end
  end

  // Soft reset sequencer
  always_comb begin
    rst_state_next = rst_state_reg;
    case (rst_state_reg)
      step_vel_pkg::RST_IDLE:
        if (soft_reset_i) rst_state_next = step_vel_pkg::RST_CLEAR;
      step_vel_pkg::RST_CLEAR: rst_state_next = step_vel_pkg::RST_WAIT;
      step_vel_pkg::RST_WAIT:
        if (rst_cnt_reg == `SOFT_RST_CYCLES)
          rst_state_next = step_vel_pkg::RST_START;
      step_vel_pkg::RST_START: rst_state_next = step_vel_pkg::RST_IDLE;
      default: rst_state_next = step_vel_pkg::RST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_vel_reg   <= 17'sd0;
      dir_reg       <= 1'b1;
      mode_reg      <= step_vel_pkg::MODE_MICRO;
      pos_reg       <= `POS_RESET;
      rst_state_reg <= step_vel_pkg::RST_IDLE;
    end else begin
      cmd_vel_reg   <= cmd_vel_next;
      dir_reg       <= !cmd_vel_next[16];
      mode_reg      <= mode_next;
      pos_reg       <= pos_next;
      rst_state_reg <= rst_state_next;
    end
  end

  // Wait counter and reset-driven controls
  wire logic in_rst = rst_state_next != step_vel_pkg::RST_IDLE
                      && rst_state_next != step_vel_pkg::RST_START;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rst_cnt_reg <= 4'd0;
      power_reg   <= 1'b1;
      halt_reg    <= 1'b0;
      auto_reg    <= 1'b0;
    end else begin
      rst_cnt_reg <= (rst_state_reg == step_vel_pkg::RST_WAIT)
                     ? rst_cnt_reg + 4'd1 : 4'd0;
      power_reg   <= !in_rst;
      halt_reg    <= in_rst;
      auto_reg    <= rst_state_next == step_vel_pkg::RST_START;
    end
  end

  // User variables, loadable from the analog code
  wire logic signed [31:0] var_wd = var_load_analog_i
                                    ? 32'($signed({1'b0, analog_reg}))
                                    : var_wdata_i;
  user_var_mem #(
    .DEPTH(VAR_DEPTH),
    .AW   (VAR_AW)
  ) u_vars (
    .core_clk_i(core_clk_i),
    .clr_i     (rst_i || rst_state_reg == step_vel_pkg::RST_CLEAR),
    .we_i      ((var_we_i || var_load_analog_i) && !halt_reg),
    .waddr_i   (var_waddr_i),
    .wdata_i   (var_wd),
    .raddr_i   (var_raddr_i),
    .rdata_o   (var_rdata_o)
  );

  // Registered outputs
  assign analog_reg_o  = analog_reg;
  assign cmd_o         = '{dir_cw: dir_reg, vel: cmd_vel_reg};
  assign mode_o        = mode_reg;
  assign position_o    = pos_reg;
  assign motor_power_o = power_reg;
  assign seq_halt_o    = halt_reg;
  assign autostart_o   = auto_reg;

  // Checks on mode switching and position stride
  a_full_needs_en: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    !cfg_i.fstep_en |=> mode_reg == step_vel_pkg::MODE_MICRO)
    else $error("full-step mode without its enable");
  a_full_at_speed: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    at_full && on_fstep |=> mode_reg == step_vel_pkg::MODE_FULL)
    else $error("full-step mode not entered at speed");
  a_micro_below: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    !at_full |=> mode_reg == step_vel_pkg::MODE_MICRO)
    else $error("microstep mode not resumed below speed");
  a_full_aligned: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    mode_reg == step_vel_pkg::MODE_FULL |-> pos_reg[5:0] == 6'h00)
    else $error("full-step mode off a full-step boundary");
  a_full_stride: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    mode_reg == step_vel_pkg::MODE_FULL && step_pulse_i && power_reg
    && rst_state_reg != step_vel_pkg::RST_CLEAR
    |=> pos_reg == $past(pos_reg) + `USTEP_PER_FSTEP
    || pos_reg == $past(pos_reg) - `USTEP_PER_FSTEP)
    else $error("full step did not move by one full step");

  // Checks on the analog path
  a_code_held: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    adc_valid_i |=> analog_reg == $past(adc_code_i))
    else $error("analog code not held");
  a_follow_scale: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    analog_follow_i && !halt_reg |=> cmd_vel_reg == $past(follow_vel))
    else $error("command does not follow the scaled code");
  a_deadband_stop: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    analog_follow_i && in_db && !halt_reg |=> cmd_vel_reg == 17'sd0)
    else $error("motion commanded inside the deadband");

  // Checks on the soft reset sequence
  a_reset_cuts: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    soft_reset_i && rst_state_reg == step_vel_pkg::RST_IDLE
    |=> !power_reg && halt_reg)
    else $error("soft reset did not halt and cut power");
  a_reset_clears: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    rst_state_reg == step_vel_pkg::RST_CLEAR |=> pos_reg == `POS_RESET)
    else $error("soft reset did not zero the position");
  a_autostart_after: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    rst_state_reg == step_vel_pkg::RST_WAIT
    && rst_cnt_reg == `SOFT_RST_CYCLES |=> auto_reg && power_reg)
    else $error("autostart not raised after soft reset");

  // Main scenarios reached
  c_enter_full: cover property (@(posedge core_clk_i) disable iff (rst_i)
    mode_reg == step_vel_pkg::MODE_MICRO
    ##1 mode_reg == step_vel_pkg::MODE_FULL);
  c_leave_full: cover property (@(posedge core_clk_i) disable iff (rst_i)
    mode_reg == step_vel_pkg::MODE_FULL
    ##1 mode_reg == step_vel_pkg::MODE_MICRO);
  c_deadband_hold: cover property (@(posedge core_clk_i) disable iff (rst_i)
    analog_follow_i && in_db && analog_vel != 17'sd0);
  c_autostart: cover property (@(posedge core_clk_i) disable iff (rst_i)
    auto_reg);
endmodule : step_mode_velocity_control

// >>> tb/winding_model.sv
`timescale 1ns/1ps
// Winding stand-in: steps at a fixed pace while powered and moving
module winding_model (
  input  wire logic                   core_clk_i,
  input  wire step_vel_pkg::vel_cmd_t cmd_i,
  input  wire logic                   power_i,
  output logic                        step_pulse_o
);
  logic [1:0] pace_reg = 2'h0;
  // One step every four cycles, none when stopped or unpowered
  always_ff @(posedge core_clk_i) begin
    pace_reg     <= pace_reg + 2'h1;
    step_pulse_o <= power_i && (cmd_i.vel != 17'sh0) && (pace_reg == 2'h3);
  end
endmodule : winding_model

// >>> tb/step_mode_velocity_control_tb.sv
`timescale 1ns/1ps
module step_mode_velocity_control_tb;
  logic                     core_clk_i, rst_i, follow, adc_valid;
  logic                     step, srst, we, ld, power, halt, auto_s;
  logic [7:0]               code, areg;
  logic [3:0]               waddr, raddr;
  logic signed [16:0]       seq_vel;
  logic signed [31:0]       wdata, rdata, pos;
  step_vel_pkg::vel_cfg_t   cfg;
  step_vel_pkg::vel_cmd_t   cmd;
  step_vel_pkg::step_mode_t mode;
  int                       n_mismatch, checks;
  // Analog code, deadband, expected sign (0 stop, 1 cw, 2 ccw)
  logic [25:0] rows [5] = '{{8'h80, 16'h0010, 2'h0},
    {8'hFF, 16'h0010, 2'h1}, {8'h00, 16'h0010, 2'h2},
    {8'h84, 16'h0A00, 2'h0}, {8'hC0, 16'h0100, 2'h1}};

  step_mode_velocity_control i_dut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .cfg_i(cfg), .analog_follow_i(follow),
    .adc_valid_i(adc_valid), .adc_code_i(code), .seq_vel_i(seq_vel),
    .step_pulse_i(step), .soft_reset_i(srst), .var_we_i(we),
    .var_waddr_i(waddr), .var_wdata_i(wdata), .var_load_analog_i(ld),
    .var_raddr_i(raddr), .var_rdata_o(rdata), .analog_reg_o(areg),
    .cmd_o(cmd), .mode_o(mode), .position_o(pos),
    .motor_power_o(power), .seq_halt_o(halt), .autostart_o(auto_s));

  winding_model i_model (.core_clk_i(core_clk_i), .cmd_i(cmd),
    .power_i(power), .step_pulse_o(step));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // Inputs move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic wait_mode(input step_vel_pkg::step_mode_t m);
    int k;
    k = 0;
    while (mode !== m && k < 400) begin
      tick(1);
      k++;
    end
    chk(32'(mode), 32'(m));
  endtask : wait_mode

  task automatic conclude;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Watchdog against a hung wait
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_i = 1'b1;
    cfg = '{1'b0, 16'h0F00, 16'h3200, 16'h0000};
    {follow, adc_valid, srst, we, ld} = 5'h00;
    code = 8'h80;
    seq_vel = 17'sh0;
    {waddr, raddr} = 8'h00;
    wdata = 32'sh0;
    tick(2);
    rst_i = 1'b0;
    tick(1);
    chk(pos, 32'h0);
    chk(32'(mode), 32'(step_vel_pkg::MODE_MICRO));
    // Analog following table
    follow = 1'b1;
    adc_valid = 1'b1;
    foreach (rows[r]) begin
      code = rows[r][25:18];
      cfg.deadband = rows[r][17:2];
      tick(4);
      chk(32'(areg), 32'(code));
      chk({30'h0, cmd.vel < 0, cmd.vel > 0}, 32'(rows[r][1:0]));
      if (cmd.vel != 0)
        chk(32'(cmd.dir_cw), 32'(rows[r][1:0] == 2'h1));
    end
    // Code 0xC0 is half scale: 25 rev/s in 8.8
    chk(32'(cmd.vel), 32'h00001900);
    cfg.analog_max = 16'h6400;
    tick(2);
    chk(32'(cmd.vel), 32'h00001900);
    cfg.analog_max = 16'h3200;
    // Analog code into a variable, plain variable write
    code = 8'h40;
    tick(2);
    ld = 1'b1;
    waddr = 4'h3;
    tick(1);
    ld = 1'b0;
    we = 1'b1;
    waddr = 4'h5;
    wdata = 32'sh1234;
    tick(1);
    we = 1'b0;
    raddr = 4'h3;
    tick(2);
    chk(rdata, 32'h40);
    raddr = 4'h5;
    tick(2);
    chk(rdata, 32'h1234);
    // Full-step switching from the sequence velocity
    follow = 1'b0;
    adc_valid = 1'b0;
    seq_vel = 17'sh01400;
    tick(200);
    chk(32'(mode), 32'(step_vel_pkg::MODE_MICRO));
    cfg.fstep_en = 1'b1;
    wait_mode(step_vel_pkg::MODE_FULL);
    tick(9);
    chk(32'(pos[5:0]), 32'h0);
    seq_vel = 17'sh00100;
    wait_mode(step_vel_pkg::MODE_MICRO);
    chk(32'(pos[5:0]), 32'h0);
    seq_vel = -17'sh01400;
    wait_mode(step_vel_pkg::MODE_FULL);
    // Soft reset
    seq_vel = 17'sh0;
    tick(4);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    tick(1);
    chk(32'(halt), 32'h1);
    tick(1);
    chk(32'(power), 32'h0);
    for (int k = 0; k < 20 && auto_s !== 1'b1; k++)
      tick(1);
    chk(32'(auto_s), 32'h1);
    chk(pos, 32'h0);
    chk(rdata, 32'h0);
    conclude();
  end
endmodule : step_mode_velocity_control_tb
